// File: psr_ctrl.sv
`timescale 1ns/1ps
// Function
// - selected load with write-low starts write, data +2
// - selected load with write-high starts read, data +2
// - selected only when first/third low, second high
// - deselected load stops; pending transfers still finish
// - bus goes high impedance two cycles after deselect
// - advance after same-type access steps burst counter
// - advance ignores read/write pin, honours byte enables
// - burst direction fixed at its loading cycle
// - clock hold high makes the edge ignored
// - suspended cycle keeps pipeline and bus state
// - data outputs high impedance after first edge
// - each byte enable gates byte plus parity
// - any byte enable combination writes those lanes
// - narrow configuration has only lanes one, two
// - burst order high interleaved, low linear
// - two-bit burst counter wraps after four beats
// - output enable high forces bus high impedance
// - sleep freezes the internal clock, keeps data

module psr_ctrl #(
   parameter int LANES  = psr_pkg::LANES_DEF,
   parameter int ADDR_W = psr_pkg::ADDR_W_DEF,
   parameter int DW     = LANES * (psr_pkg::BYTE_W + 1)
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Synchronous control pins
   input  wire logic              i_clock_hold_n,
   input  wire logic              i_chip_select_first_n,
   input  wire logic              i_chip_select_second,
   input  wire logic              i_chip_select_third_n,
   input  wire logic              i_advance_not_load,
   input  wire logic              i_read_not_write,
   input  wire logic [LANES-1:0]  i_byte_write_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic              i_burst_order_select,
   // Asynchronous pins
   input  wire logic              i_output_enable_n,
   input  wire logic              i_sleep_request,
   // Data pins, bytes low then parity bits high
   input  wire logic [DW-1:0]     i_data,
   output logic [DW-1:0]          o_data,
   output logic                   o_data_oe,
   // Status
   output logic                   o_asleep
);

   localparam int PB = LANES * psr_pkg::BYTE_W;
   // A buffered write word is address, per-bit lane mask and data
   localparam int WBW = ADDR_W + 2 * DW;

   logic [DW-1:0] mem [2**ADDR_W];

   // Asynchronous pins: three stages, a change counts when the last two agree
   logic [psr_pkg::SYNC_DEPTH-1:0] oe_sync_ff, nxt_oe_sync;
   logic [psr_pkg::SYNC_DEPTH-1:0] sl_sync_ff, nxt_sl_sync;
   logic                           oe_n_ff, nxt_oe_n;
   logic                           sleep_ff, nxt_sleep;

   always_comb begin
      nxt_oe_sync = {oe_sync_ff[1:0], i_output_enable_n};
      nxt_sl_sync = {sl_sync_ff[1:0], i_sleep_request};
      nxt_oe_n    = (oe_sync_ff[1] == oe_sync_ff[2]) ? oe_sync_ff[2] : oe_n_ff;
      nxt_sleep   = (sl_sync_ff[1] == sl_sync_ff[2]) ? sl_sync_ff[2] : sleep_ff;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         oe_sync_ff <= '1;
         sl_sync_ff <= '0;
         oe_n_ff    <= psr_pkg::PIN_HIGH_RST;
         sleep_ff   <= psr_pkg::PIN_LOW_RST;
      end else begin
         oe_sync_ff <= nxt_oe_sync;
         sl_sync_ff <= nxt_sl_sync;
         oe_n_ff    <= nxt_oe_n;
         sleep_ff   <= nxt_sleep;
      end
   end

   // Pipeline state
   psr_pkg::psr_op_type      burst_ff, nxt_burst;
   psr_pkg::psr_op_type      s1_op_ff, nxt_s1_op;
   psr_pkg::psr_op_type      s2_op_ff, nxt_s2_op;
   logic [ADDR_W-1:0]        base_ff, nxt_base;
   logic [psr_pkg::BURST_W-1:0] cnt_ff, nxt_cnt;
   logic [ADDR_W-1:0]        s1_addr_ff, nxt_s1_addr;
   logic [ADDR_W-1:0]        s2_addr_ff, nxt_s2_addr;
   logic [LANES-1:0]         s1_bw_ff, nxt_s1_bw;
   logic [LANES-1:0]         s2_bw_ff, nxt_s2_bw;
   logic [DW-1:0]            o_data_ff, nxt_data;
   logic                     drive_ff, nxt_drive;
   logic                     o_data_oe_ff, nxt_data_oe;

   logic                     selected;
   logic                     en;
   logic                     wb_ready, wb_pending, wb_valid, wb_push;
   logic [WBW-1:0]           wb_out;
   logic [psr_pkg::BURST_W-1:0] step;
   logic [DW-1:0]            lane_mask, wr_mask, rd_word;

   assign selected = !i_chip_select_first_n && !i_chip_select_third_n
                     && i_chip_select_second;

   // A read may not overtake a write still parked in the buffer
   assign en = !i_clock_hold_n && !sleep_ff && wb_ready
               && !((s1_op_ff == psr_pkg::OP_READ) && wb_pending);

   assign wb_push = en && (s2_op_ff == psr_pkg::OP_WRITE);

   // Lane k: byte bits plus one parity bit above all bytes
   generate
      for (genvar k = 0; k < LANES; k++) begin : g_lane
         assign lane_mask[k*psr_pkg::BYTE_W +: psr_pkg::BYTE_W] =
            {psr_pkg::BYTE_W{!s2_bw_ff[k]}};
         assign lane_mask[PB + k] = !s2_bw_ff[k];
      end
   endgenerate

   assign wr_mask = wb_out[DW-1:0];

   always_comb begin
      nxt_burst   = burst_ff;
      nxt_base    = base_ff;
      nxt_cnt     = cnt_ff;
      nxt_s1_op   = s1_op_ff;
      nxt_s1_addr = s1_addr_ff;
      nxt_s1_bw   = s1_bw_ff;
      nxt_s2_op   = s2_op_ff;
      nxt_s2_addr = s2_addr_ff;
      nxt_s2_bw   = s2_bw_ff;
      nxt_data    = o_data_ff;
      nxt_drive   = drive_ff;
      step        = cnt_ff + 2'h1;
      rd_word     = mem[s1_addr_ff];
      if (en) begin
         nxt_s2_op   = s1_op_ff;
         nxt_s2_addr = s1_addr_ff;
         nxt_s2_bw   = s1_bw_ff;
         nxt_s1_bw   = i_byte_write_n;
         if (!i_advance_not_load) begin
            if (selected) begin
               nxt_burst   = i_read_not_write ? psr_pkg::OP_READ
                                              : psr_pkg::OP_WRITE;
               nxt_s1_op   = nxt_burst;
               nxt_base    = i_addr;
               nxt_cnt     = psr_pkg::BURST_CNT_RST;
               nxt_s1_addr = i_addr;
            end else begin
               nxt_burst = psr_pkg::OP_NONE;
               nxt_s1_op = psr_pkg::OP_NONE;
            end
         end else if (burst_ff != psr_pkg::OP_NONE) begin
            nxt_cnt     = step;
            nxt_s1_op   = burst_ff;
            nxt_s1_addr = base_ff;
            nxt_s1_addr[1:0] = i_burst_order_select ? (base_ff[1:0] ^ step)
                                                    : (base_ff[1:0] + step);
         end else begin
            nxt_s1_op = psr_pkg::OP_NONE;
         end
         // Data for the slot now entering its bus cycle
         nxt_drive = (s1_op_ff == psr_pkg::OP_READ);
         if (s1_op_ff == psr_pkg::OP_READ) begin
            // Forward a write landing on the same word at this very edge
            if ((s2_op_ff == psr_pkg::OP_WRITE) && (s2_addr_ff == s1_addr_ff)) begin
               nxt_data = (i_data & lane_mask) | (rd_word & ~lane_mask);
            end else begin
               nxt_data = rd_word;
            end
         end
      end
      nxt_data_oe = nxt_drive && !oe_n_ff;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         burst_ff     <= psr_pkg::OP_NONE;
         s1_op_ff     <= psr_pkg::OP_NONE;
         s2_op_ff     <= psr_pkg::OP_NONE;
         base_ff      <= '0;
         cnt_ff       <= psr_pkg::BURST_CNT_RST;
         s1_addr_ff   <= '0;
         s2_addr_ff   <= '0;
         s1_bw_ff     <= '1;
         s2_bw_ff     <= '1;
         o_data_ff    <= '0;
         drive_ff     <= 1'b0;
         o_data_oe_ff <= 1'b0;
      end else begin
         burst_ff     <= nxt_burst;
         s1_op_ff     <= nxt_s1_op;
         s2_op_ff     <= nxt_s2_op;
         base_ff      <= nxt_base;
         cnt_ff       <= nxt_cnt;
         s1_addr_ff   <= nxt_s1_addr;
         s2_addr_ff   <= nxt_s2_addr;
         s1_bw_ff     <= nxt_s1_bw;
         s2_bw_ff     <= nxt_s2_bw;
         o_data_ff    <= nxt_data;
         drive_ff     <= nxt_drive;
         o_data_oe_ff <= nxt_data_oe;
      end
   end

   // Write words queue here; the array stops taking them while asleep
   psr_wbuf #(
      .W (WBW)
   ) u_wbuf (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_valid   (wb_push),
      .i_data    ({s2_addr_ff, lane_mask, i_data}),
      .o_ready   (wb_ready),
      .o_valid   (wb_valid),
      .o_data    (wb_out),
      .i_ready   (!sleep_ff),
      .o_pending (wb_pending)
   );

   // Stored data survives sleep: the array simply takes no words then
   always_ff @(posedge i_clk) begin
      if (wb_valid && !sleep_ff) begin
         mem[wb_out[WBW-1 -: ADDR_W]] <= (wb_out[DW +: DW] & wr_mask)
            | (mem[wb_out[WBW-1 -: ADDR_W]] & ~wb_out[DW +: DW]);
      end
   end

   assign o_data    = o_data_ff;
   assign o_data_oe = o_data_oe_ff;
   assign o_asleep  = sleep_ff;

   logic sel_load_rd, sel_load_wr, desel;
   assign sel_load_rd = en && selected && !i_advance_not_load && i_read_not_write;
   assign sel_load_wr = en && selected && !i_advance_not_load && !i_read_not_write;
   assign desel       = en && !selected && !i_advance_not_load;

   chk_read_latency: assert property (@(posedge i_clk) disable iff (i_rst)
      sel_load_rd ##1 en |=> drive_ff)
      else $error("read did not drive bus two cycles after load");

   chk_write_capture: assert property (@(posedge i_clk) disable iff (i_rst)
      sel_load_wr ##1 en ##1 en |-> wb_push)
      else $error("write data not taken two cycles after load");

   chk_deselect_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
      desel ##1 en |=> !drive_ff && !o_data_oe)
      else $error("bus not released two cycles after deselect");

   chk_suspend_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !en |=> $stable(s1_op_ff) && $stable(s2_op_ff) && $stable(o_data)
              && $stable(drive_ff) && $stable(cnt_ff))
      else $error("pipeline changed in a suspended cycle");

   chk_reset_hiz: assert property (@(posedge i_clk)
      i_rst |=> !o_data_oe)
      else $error("bus driven after reset edge");

   chk_oe_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      oe_n_ff |=> !o_data_oe)
      else $error("bus driven while output enable high");

   chk_burst_step: assert property (@(posedge i_clk) disable iff (i_rst)
      en && i_advance_not_load && (burst_ff != psr_pkg::OP_NONE)
      |=> cnt_ff == 2'($past(cnt_ff) + 2'h1))
      else $error("burst counter did not step");

   chk_burst_kind: assert property (@(posedge i_clk) disable iff (i_rst)
      en && i_advance_not_load && (burst_ff == psr_pkg::OP_READ)
      |=> s1_op_ff == psr_pkg::OP_READ)
      else $error("burst direction not kept");

   chk_noop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      en && i_advance_not_load && (burst_ff == psr_pkg::OP_NONE)
      |=> s1_op_ff == psr_pkg::OP_NONE)
      else $error("advance after idle started an access");

   chk_sleep_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
      sleep_ff |=> $stable(s1_op_ff) && $stable(burst_ff) && $stable(cnt_ff)
                   && $stable(s1_addr_ff))
      else $error("pipeline ran while asleep");

   chk_mask_none: assert property (@(posedge i_clk) disable iff (i_rst)
      wb_push && (s2_bw_ff == '1) |-> lane_mask == '0)
      else $error("write with no enables produced a mask");

   chk_load_addr: assert property (@(posedge i_clk) disable iff (i_rst)
      sel_load_rd |=> (s1_op_ff == psr_pkg::OP_READ) && (s1_addr_ff == $past(i_addr)))
      else $error("read load did not take the external address");

   cov_load_read: cover property (@(posedge i_clk) disable iff (i_rst)
      sel_load_rd ##1 en ##1 o_data_oe);
   cov_burst_write: cover property (@(posedge i_clk) disable iff (i_rst)
      sel_load_wr ##1 (en && i_advance_not_load) ##1 wb_push);
   cov_suspend: cover property (@(posedge i_clk) disable iff (i_rst)
      drive_ff && !en);
   cov_sleep_block: cover property (@(posedge i_clk) disable iff (i_rst)
      sleep_ff && !i_clock_hold_n && selected);

endmodule : psr_ctrl

// File: psr_host_bus.sv
`timescale 1ns/1ps

module psr_host_bus #(
   parameter int DW = 36
) (
   // Clock
   input  wire logic          i_clk,
   // Write data offered by the host
   input  wire logic          i_drive,
   input  wire logic [DW-1:0] i_wdata,
   // Host side of the shared data lines
   output logic [DW-1:0]      o_bus
);
   logic [DW-1:0] last_ff = '0;

   // A released bus flips every cycle so a stale word never looks like fresh data
   always_ff @(posedge i_clk) begin
      last_ff <= o_bus;
   end

   // Write data stands only in its data cycle, two acting edges after the load
   assign o_bus = i_drive ? i_wdata : ~last_ff;
endmodule : psr_host_bus

// File: psr_pkg.sv
package psr_pkg;

   // Geometry defaults
   localparam int LANES_DEF   = 4;
   localparam int ADDR_W_DEF  = 18;
   localparam int BYTE_W      = 8;
   localparam int BURST_W     = 2;
   localparam int SYNC_DEPTH  = 3;
   localparam int WBUF_DEPTH  = 2;

   // Reset values
   localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
   localparam logic               PIN_HIGH_RST  = 1'b1;
   localparam logic               PIN_LOW_RST   = 1'b0;

   // Pipeline slot contents
   typedef enum logic [2:0] {
      OP_NONE  = 3'b001,
      OP_READ  = 3'b010,
      OP_WRITE = 3'b100
   } psr_op_type;

endpackage : psr_pkg

// File: psr_wbuf.sv
`timescale 1ns/1ps

module psr_wbuf #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Filling side
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_data,
   output logic              o_ready,
   // Draining side
   output logic              o_valid,
   output logic [W-1:0]      o_data,
   input  wire logic         i_ready,
   // Status
   output logic              o_pending
);

   logic [W-1:0] slot_ff [psr_pkg::WBUF_DEPTH];
   logic [1:0]   cnt_ff;
   logic [1:0]   nxt_cnt;
   logic         rd_ff;
   logic         nxt_rd;
   logic         wr_ff;
   logic         nxt_wr;
   logic         store;
   logic         take;

   // An empty buffer passes the word straight through, so it adds no latency
   assign o_valid   = (cnt_ff != 2'h0) || i_valid;
   assign o_data    = (cnt_ff != 2'h0) ? slot_ff[rd_ff] : i_data;
   assign o_ready   = (cnt_ff != 2'h2);
   assign o_pending = (cnt_ff != 2'h0);

   always_comb begin
      take    = (cnt_ff != 2'h0) && i_ready;
      store   = i_valid && o_ready && !((cnt_ff == 2'h0) && i_ready);
      nxt_cnt = cnt_ff + 2'(store) - 2'(take);
      nxt_rd  = take ? !rd_ff : rd_ff;
      nxt_wr  = store ? !wr_ff : wr_ff;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_ff <= 2'h0;
         rd_ff  <= 1'b0;
         wr_ff  <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         rd_ff  <= nxt_rd;
         wr_ff  <= nxt_wr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (store) begin
         slot_ff[wr_ff] <= i_data;
      end
   end

endmodule : psr_wbuf

// File: testbench.sv
`timescale 1ns/1ps

module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hold_n = 1'b0;
   logic        cs1_n = 1'b1;
   logic        cs2 = 1'b0;
   logic        cs3_n = 1'b1;
   logic        adv = 1'b0;
   logic        rnw = 1'b1;
   logic [3:0]  bw_n = 4'hf;
   logic [5:0]  addr = 6'h00;
   logic        order_sel = 1'b0;
   logic        oe_n = 1'b0;
   logic        sleep = 1'b0;
   logic        nap = 1'b0;
   logic [4:0]  oe_dly = 5'h1f;
   logic        drive = 1'b0;
   logic [35:0] wdata = 36'h0;
   logic [35:0] data_in;
   logic [35:0] data_out;
   logic        data_oe;
   logic        asleep;
   logic [35:0] mem [64];
   logic [35:0] exp_d = 36'h0;
   logic        exp_oe = 1'b0;
   int          p_op [2] = '{0, 0};
   logic [5:0]  p_addr [2];
   logic [3:0]  p_be [2];
   logic [35:0] p_dat [2];
   int          b_type = 0;
   logic [5:0]  b_base = 6'h00;
   logic [1:0]  b_cnt = 2'h0;
   int          seed = 32'hf296;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          r;

   always #10 clk = ~clk;

   psr_ctrl #(.LANES(4), .ADDR_W(6)) psr_ctrl_inst (
      .i_clk(clk), .i_rst(rst), .i_clock_hold_n(hold_n),
      .i_chip_select_first_n(cs1_n), .i_chip_select_second(cs2),
      .i_chip_select_third_n(cs3_n), .i_advance_not_load(adv),
      .i_read_not_write(rnw), .i_byte_write_n(bw_n), .i_addr(addr),
      .i_burst_order_select(order_sel), .i_output_enable_n(oe_n),
      .i_sleep_request(sleep), .i_data(data_in),
      .o_data(data_out), .o_data_oe(data_oe), .o_asleep(asleep)
   );

   psr_host_bus #(.DW(36)) psr_host_bus_inst (
      .i_clk(clk), .i_drive(drive), .i_wdata(wdata), .o_bus(data_in)
   );

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // Kinds: 0 suspend, 1 deselect, 2 load read, 3 load write, 4 advance
   task automatic issue(input int kind, input logic [5:0] a, input logic [3:0] be);
      logic [3:0]  rnd;
      logic [35:0] d;
      int          op;
      logic [5:0]  ea;
      rnd = 4'($random(seed));
      d = {4'($random(seed)), 32'($random(seed))};
      op = 0;
      ea = a;
      // While napping every edge acts at the pins; only sleep may hold the pipeline
      hold_n = (kind == 0) && !nap;
      cs1_n = (kind == 1) ? (rnd[1:0] == 2'h0) : (kind == 0) & rnd[0];
      cs2 = !((kind == 1) && rnd[1:0] == 2'h1);
      cs3_n = (kind == 1) && rnd[1];
      adv = (kind == 4) || (kind == 0 && rnd[2]);
      rnw = (kind == 2) ? 1'b1 : (kind == 3) ? 1'b0 : rnd[3];
      bw_n = be;
      addr = a;
      drive = (p_op[1] == 2);
      wdata = p_dat[1];
      if (kind == 2 || kind == 3) begin
         op = kind - 1;
         b_type = op;
         b_base = a;
         b_cnt = 2'h0;
      end else if (kind == 1) begin
         b_type = 0;
      end else if (kind == 4 && b_type != 0) begin
         b_cnt = b_cnt + 2'h1;
         op = b_type;
         ea = {b_base[5:2], order_sel ? b_base[1:0] ^ b_cnt : b_base[1:0] + b_cnt};
      end
      @(posedge clk);
      if (kind != 0) begin
         if (p_op[1] == 2) begin
            for (int l = 0; l < 4; l++) begin
               if (!p_be[1][l]) begin
                  mem[p_addr[1]][l*8 +: 8] = p_dat[1][l*8 +: 8];
                  mem[p_addr[1]][32+l] = p_dat[1][32+l];
               end
            end
         end
         // Read data shares the bus cycle of write data, so the read in stage one
         // goes out after this edge and already sees the write landing now
         exp_oe = (p_op[0] == 1);
         if (p_op[0] == 1)
            exp_d = mem[p_addr[0]];
         p_op[1] = p_op[0];
         p_addr[1] = p_addr[0];
         p_be[1] = p_be[0];
         p_dat[1] = p_dat[0];
         p_op[0] = op;
         p_addr[0] = ea;
         p_be[0] = be;
         p_dat[0] = d;
      end
      @(negedge clk);
      chk({35'h0, data_oe}, {35'h0, exp_oe && !oe_dly[4]});
      if (exp_oe && !oe_dly[4])
         chk(data_out, exp_d);
   endtask : issue

   // A hang is cut short well past the roughly 900 cycles the run needs
   always @(posedge clk) begin
      // The output-enable pin reaches the bus enable five edges later
      oe_dly <= {oe_dly[3:0], oe_n};
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({35'h0, data_oe}, 36'h0);
      rst = 1'b0;
      // Idle lets the output-enable synchroniser settle
      repeat (6) issue(1, 6'h00, 4'hf);
      // Back-to-back full writes give every word a known value
      for (int i = 0; i < 64; i++) issue(3, 6'(i), 4'h0);
      for (int ph = 0; ph < 2; ph++) begin
         issue(1, 6'h00, 4'hf);
         issue(1, 6'h00, 4'hf);
         order_sel = ph[0];
         for (int n = 0; n < 400; n++) begin
            oe_n = (n >= 200) && (n < 230);
            r = $unsigned($random(seed)) % 10;
            issue(r < 2 ? r : r < 4 ? 2 : r < 6 ? 3 : 4, 6'($random(seed)),
                  4'($random(seed)));
         end
      end
      // Random commands while asleep must leave pipeline and bus untouched
      sleep = 1'b1;
      repeat (4) issue(0, 6'h00, 4'hf);
      chk({35'h0, asleep}, 36'h1);
      nap = 1'b1;
      repeat (8) issue(0, 6'($random(seed)), 4'($random(seed)));
      sleep = 1'b0;
      repeat (4) issue(0, 6'($random(seed)), 4'($random(seed)));
      nap = 1'b0;
      chk({35'h0, asleep}, 36'h0);
      repeat (3) issue(1, 6'h00, 4'hf);
      end_of_test();
   end
endmodule : testbench
